// ===== logic/fmc_defines.svh
`ifndef FMC_DEFINES_SVH
`define FMC_DEFINES_SVH

// ----------------------------------------
// reference clock
// ----------------------------------------
`define FMC_CLK_NS 20

// ----------------------------------------
// transmit squelch and idle
// ----------------------------------------
`define FMC_TX_ON_NS 20
`define FMC_TX_ON_CYC ((`FMC_TX_ON_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_TX_SOI_NS 180
`define FMC_TX_SOI_CYC ((`FMC_TX_SOI_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_IDLE_KHZ 1000
`define FMC_IDLE_HALF_CYC (500000 / `FMC_IDLE_KHZ / `FMC_CLK_NS)

// ----------------------------------------
// receive squelch and low light
// ----------------------------------------
`define FMC_RX_SQ_KHZ 2510
`define FMC_RX_GAP_CYC ((500000000 / (`FMC_RX_SQ_KHZ * 1000)) / `FMC_CLK_NS)
`define FMC_RX_SOI_NS 160
`define FMC_RX_SOI_CYC (`FMC_RX_SOI_NS / `FMC_CLK_NS)
`define FMC_RX_CLOSE_NEED 2
`define FMC_LL_NS 3000
`define FMC_LL_CYC (`FMC_LL_NS / `FMC_CLK_NS)

// ----------------------------------------
// collision oscillator and heartbeat test
// ----------------------------------------
`define FMC_COL_KHZ 10000
`define FMC_COL_CYC (1000000 / `FMC_COL_KHZ / `FMC_CLK_NS)
`define FMC_COL_HI_CYC (`FMC_COL_CYC - `FMC_COL_CYC / 2)
`define FMC_SQE_DLY_NS 1000
`define FMC_SQE_DLY_CYC ((`FMC_SQE_DLY_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_SQE_DUR_NS 1000
`define FMC_SQE_DUR_CYC ((`FMC_SQE_DUR_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)

// ----------------------------------------
// long timers (ms)
// ----------------------------------------
`define FMC_JAB_MS 20
`define FMC_JAB_CYC (`FMC_JAB_MS * 1000000 / `FMC_CLK_NS)
`define FMC_UNJAB_MS 500
`define FMC_UNJAB_CYC (`FMC_UNJAB_MS * 1000000 / `FMC_CLK_NS)
`define FMC_LED_MS 16
`define FMC_LED_CYC (`FMC_LED_MS * 1000000 / `FMC_CLK_NS)
`define FMC_LCW 25

`endif

// ===== logic/fmc_pkg.sv
package fmc_pkg;
    `include "fmc_defines.svh"

    typedef enum logic [1:0] {JB_OK, JB_ON} fmc_jab_t;
    typedef enum logic [1:0] {SQE_IDLE, SQE_WAIT, SQE_BURST} fmc_sqe_t;

    typedef struct packed {
        logic tx_act;
        logic tx_was;
        logic [7:0] tx_low;
        logic [7:0] tx_high;
        logic rx_act;
        logic rx_prev;
        logic [7:0] rx_gap;
        logic [1:0] rx_close;
        logic [5:0] idle_div;
        logic idle_ph;
        logic [2:0] col_div;
        fmc_sqe_t sqe;
        logic [5:0] sqe_cnt;
        fmc_jab_t babble_guard_led;
        logic [`FMC_LCW-1:0] jab_cnt;
        logic col_act;
        logic fiber;
        logic di;
        logic di_act;
        logic col;
        logic jab_led_n;
        logic ll_led_n;
    } fmc_state_t;
endpackage

// ===== logic/fmc_sync.sv
`timescale 1ns/100ps
module fmc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // pins in, qualified levels out
    input wire logic [W-1:0] a,
    output logic [W-1:0] y
);
    import fmc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] y;
    } fmc_sync_t;

    fmc_sync_t r, n;

    always_comb begin
        n = r;
        n.s1 = a;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // a change only counts once two settled stages agree
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.y[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign y = r.y;
endmodule // fmc_sync

// ===== logic/fmc_stretch.sv
`timescale 1ns/100ps
`include "fmc_defines.svh"
module fmc_stretch #(
    parameter int unsigned LEN = `FMC_LED_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // event level in, active low lamp out
    input wire logic trig,
    output logic led_n
);
    import fmc_pkg::*;

    localparam logic [`FMC_LCW-1:0] LIM = `FMC_LCW'(LEN);

    typedef struct packed {
        logic [`FMC_LCW-1:0] cnt;
        logic led_n;
    } fmc_str_t;

    fmc_str_t r, n;

    always_comb begin
        n = r;
        // every new event reloads the timer, so rapid events stay lit
        if (trig) begin
            n.cnt = LIM;
        end else if (r.cnt != '0) begin
            n.cnt = r.cnt - `FMC_LCW'(1);
        end
        n.led_n = (n.cnt == '0);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '{cnt: '0, led_n: 1'b1};
        end else begin
            r <= n;
        end
    end

    assign led_n = r.led_n;
endmodule // fmc_stretch

// ===== logic/fmc_top.sv
// Functional notes
// - Transmit squelch ignores negative pulses under 20ns or above -250mV.
// - Transmit resquelches after DO stays positive longer than 180ns.
// - LED sinks current while DO negative, off while DO positive.
// - At most two leading transmit bits are lost.
// - Start-up delay varies by at most 200ns between close packets.
// - After transmit start of idle, fiber carries 1MHz idle.
// - At most 2.5 leading receive bits are dropped.
// - Receive squelch rejects below 2.51MHz and all input in low light.
// - Receive returns to squelch after 160ns of fiber idle.
// - Collision when transmit and receive both active, unless loopback off.
// - Collision output is 10MHz square wave, duty within 60/40.
// - With loopback enabled, DO data echoes onto DI.
// - In collision DI carries fiber data until receive idles.
// - Loopback-off strap gives full duplex, no loopback, no collision.
// - SQE test burst about 1us after each transmit, not in low light/jabber.
// - SQE test only when heartbeat strap high.
// - Transmit over 20ms disables transmitter and turns collision on.
// - After 0.5s continuous DO idle, jabber clears.
// - Fiber still carries 1MHz idle while jabber disables transmit.
// - Tx, rx, collision LEDs active low, stretched, retriggered.
// - Jabber and low-light LEDs active low, unstretched.
// - Low-light LED low only with input low and transitions under 3us.
// - Stretched LED pulses last 8 to 32ms, nominally 16.
// - SQE burst starts 0.6 to 1.6us after transmit inactive.
`timescale 1ns/100ps
`include "fmc_defines.svh"
module fmc_top #(
    parameter int unsigned JAB_CYC = `FMC_JAB_CYC,
    parameter int unsigned UNJAB_CYC = `FMC_UNJAB_CYC,
    parameter int unsigned LED_CYC = `FMC_LED_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // attachment unit side
    input wire logic do_neg_in,
    output logic di_data_out,
    output logic di_active_out,
    output logic col_out,
    // fiber side
    output logic fiber_led_sink_out,
    input wire logic fiber_receive_in,
    input wire logic low_light_detect_in,
    // straps
    input wire logic loopback_off_strap,
    input wire logic heartbeat_test_strap,
    // status lamps
    output logic transmit_led_n,
    output logic receive_led_n,
    output logic collision_led_n,
    output logic babble_guard_led_n,
    output logic low_light_led_n
);
    import fmc_pkg::*;

    // ----------------------------------------
    // limits at counter width
    // ----------------------------------------
    localparam logic [7:0] TX_ON = 8'(`FMC_TX_ON_CYC);
    localparam logic [7:0] TX_SOI = 8'(`FMC_TX_SOI_CYC);
    localparam logic [7:0] RX_GAP = 8'(`FMC_RX_GAP_CYC);
    localparam logic [7:0] RX_SOI = 8'(`FMC_RX_SOI_CYC);
    localparam logic [7:0] LL_LIM = 8'(`FMC_LL_CYC);
    localparam logic [1:0] RX_NEED = 2'(`FMC_RX_CLOSE_NEED);
    localparam logic [5:0] IDLE_HALF = 6'(`FMC_IDLE_HALF_CYC);
    localparam logic [2:0] COL_LAST = 3'(`FMC_COL_CYC - 1);
    localparam logic [2:0] COL_HI = 3'(`FMC_COL_HI_CYC);
    localparam logic [5:0] SQE_DLY = 6'(`FMC_SQE_DLY_CYC);
    localparam logic [5:0] SQE_DUR = 6'(`FMC_SQE_DUR_CYC);
    localparam logic [`FMC_LCW-1:0] JAB_LIM = `FMC_LCW'(JAB_CYC);
    localparam logic [`FMC_LCW-1:0] UNJAB_LIM = `FMC_LCW'(UNJAB_CYC);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] sat_inc8(input logic [7:0] v);
        sat_inc8 = (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    // ----------------------------------------
    // pin qualification
    // ----------------------------------------
    logic [4:0] pins_s;
    logic do_s;
    logic rx_s;
    logic lld_s;
    logic lbo_s;
    logic hbt_s;

    fmc_sync #(.W(5)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .a({do_neg_in, fiber_receive_in, low_light_detect_in,
            loopback_off_strap, heartbeat_test_strap}),
        .y(pins_s)
    );

    assign {do_s, rx_s, lld_s, lbo_s, hbt_s} = pins_s;

    // ----------------------------------------
    // main state
    // ----------------------------------------
    fmc_state_t r, n;
    logic rx_edge;
    logic tx_en;
    logic tx_end;
    logic collide;
    logic col_on;

    always_comb begin
        n = r;
        rx_edge = rx_s ^ r.rx_prev;
        tx_en = (r.babble_guard_led == JB_OK);
        tx_end = r.tx_was & ~r.tx_act;
        // loopback off means no collision detection at all
        collide = r.tx_act & r.rx_act & ~lbo_s;
        col_on = collide | (r.sqe == SQE_BURST) | ~tx_en;

        // transmit squelch: run lengths of negative and positive DO
        n.tx_was = r.tx_act;
        if (do_s) begin
            n.tx_low = sat_inc8(r.tx_low);
            n.tx_high = 8'h00;
        end else begin
            n.tx_low = 8'h00;
            n.tx_high = sat_inc8(r.tx_high);
        end
        // do_neg_in is the -250mV comparator; one-sample blips are noise
        if (!r.tx_act && n.tx_low > TX_ON) begin
            n.tx_act = 1'b1;
        end
        if (r.tx_act && n.tx_high > TX_SOI) begin
            n.tx_act = 1'b0;
        end

        // receive squelch: gaps between fiber transitions
        n.rx_prev = rx_s;
        if (rx_edge) begin
            n.rx_gap = 8'h00;
            if (r.rx_gap <= RX_GAP) begin
                n.rx_close = (r.rx_close == RX_NEED) ? r.rx_close
                                                     : r.rx_close + 2'h1;
            end else begin
                n.rx_close = 2'h0;
            end
        end else begin
            n.rx_gap = sat_inc8(r.rx_gap);
        end
        // edges seen in low light must not count once light returns
        if (lld_s) begin
            n.rx_close = 2'h0;
        end
        if (!r.rx_act && n.rx_close == RX_NEED && !lld_s) begin
            n.rx_act = 1'b1;
        end
        if (r.rx_act && (r.rx_gap > RX_SOI || lld_s)) begin
            n.rx_act = 1'b0;
            n.rx_close = 2'h0;
        end

        // free running dividers: idle tone and collision tone
        if (r.idle_div == IDLE_HALF - 6'h01) begin
            n.idle_div = 6'h00;
            n.idle_ph = ~r.idle_ph;
        end else begin
            n.idle_div = r.idle_div + 6'h01;
        end
        n.col_div = (r.col_div == COL_LAST) ? 3'h0 : r.col_div + 3'h1;

        // jabber watchdog and unjab timer share one counter
        unique case (r.babble_guard_led)
            JB_OK: begin
                if (r.tx_act) begin
                    n.jab_cnt = r.jab_cnt + `FMC_LCW'(1);
                    if (r.jab_cnt >= JAB_LIM - `FMC_LCW'(1)) begin
                        n.babble_guard_led = JB_ON;
                        n.jab_cnt = '0;
                    end
                end else begin
                    n.jab_cnt = '0;
                end
            end
            JB_ON: begin
                // any transmit activity restarts the idle count
                if (r.tx_act) begin
                    n.jab_cnt = '0;
                end else if (r.jab_cnt >= UNJAB_LIM - `FMC_LCW'(1)) begin
                    n.babble_guard_led = JB_OK;
                    n.jab_cnt = '0;
                end else begin
                    n.jab_cnt = r.jab_cnt + `FMC_LCW'(1);
                end
            end
            default: begin
                n.babble_guard_led = JB_OK;
                n.jab_cnt = '0;
            end
        endcase

        // heartbeat test after each packet end
        unique case (r.sqe)
            SQE_IDLE: begin
                n.sqe_cnt = 6'h00;
                if (tx_end && hbt_s && !lld_s && tx_en) begin
                    n.sqe = SQE_WAIT;
                end
            end
            SQE_WAIT: begin
                n.sqe_cnt = r.sqe_cnt + 6'h01;
                if (!tx_en || lld_s || !hbt_s) begin
                    n.sqe = SQE_IDLE;
                end else if (r.sqe_cnt == SQE_DLY - 6'h01) begin
                    n.sqe = SQE_BURST;
                    n.sqe_cnt = 6'h00;
                end
            end
            SQE_BURST: begin
                n.sqe_cnt = r.sqe_cnt + 6'h01;
                if (r.sqe_cnt == SQE_DUR - 6'h01) begin
                    n.sqe = SQE_IDLE;
                end
            end
            default: begin
                n.sqe = SQE_IDLE;
                n.sqe_cnt = 6'h00;
            end
        endcase

        // collision pair: 3 high, 2 low of a 100ns period
        n.col_act = col_on;
        n.col = col_on & (r.col_div < COL_HI);

        // fiber LED: data while transmitting, idle tone otherwise
        if (r.tx_act && tx_en) begin
            n.fiber = do_s;
        end else begin
            n.fiber = r.idle_ph;
        end

        // receive pair: fiber data wins, so a collision shows fiber data
        if (r.rx_act) begin
            n.di = rx_s;
            n.di_act = 1'b1;
        end else if (r.tx_act && !lbo_s) begin
            n.di = do_s;
            n.di_act = 1'b1;
        end else begin
            n.di = 1'b0;
            n.di_act = 1'b0;
        end

        // direct lamps
        n.jab_led_n = tx_en;
        n.ll_led_n = ~(~lld_s & (r.rx_gap < LL_LIM));
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
            r.babble_guard_led <= JB_OK;
            r.sqe <= SQE_IDLE;
            r.jab_led_n <= 1'b1;
            r.ll_led_n <= 1'b1;
            r.rx_gap <= 8'hFF;
            r.tx_high <= 8'hFF;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // stretched lamps
    // ----------------------------------------
    fmc_stretch #(.LEN(LED_CYC)) u_tx_led (
        .mclk(mclk),
        .srst(srst),
        .trig(r.tx_act),
        .led_n(transmit_led_n)
    );

    fmc_stretch #(.LEN(LED_CYC)) u_rx_led (
        .mclk(mclk),
        .srst(srst),
        .trig(r.rx_act),
        .led_n(receive_led_n)
    );

    fmc_stretch #(.LEN(LED_CYC)) u_col_led (
        .mclk(mclk),
        .srst(srst),
        .trig(r.col_act),
        .led_n(collision_led_n)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign fiber_led_sink_out = r.fiber;
    assign di_data_out = r.di;
    assign di_active_out = r.di_act;
    assign col_out = r.col;
    assign babble_guard_led_n = r.jab_led_n;
    assign low_light_led_n = r.ll_led_n;
endmodule // fmc_top

// ===== sim/fmc_monitor.sv
`timescale 1ns/100ps
module fmc_monitor #(
    parameter int unsigned LED_CYC = 100
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // pins in
    input wire logic do_neg_in,
    input wire logic fiber_receive_in,
    input wire logic low_light_detect_in,
    input wire logic loopback_off_strap,
    input wire logic heartbeat_test_strap,
    // pins out
    input wire logic di_active_out,
    input wire logic col_out,
    input wire logic fiber_led_sink_out,
    input wire logic transmit_led_n,
    input wire logic babble_guard_led_n,
    input wire logic low_light_led_n
);
    // ----------------------------------------
    // run counters
    // ----------------------------------------
    logic [5:0] ll_cnt, do_idle, rx_quiet, jab_run, fib_run, quiet_cnt;
    logic rx_prev, fib_prev;
    int unsigned tl_run;

    // saturate so long idles never wrap back under a threshold
    function automatic logic [5:0] inc(input logic [5:0] v);
        return v + 6'(v != 6'h3F);
    endfunction

    always_ff @(posedge mclk) begin
        rx_prev <= fiber_receive_in;
        fib_prev <= fiber_led_sink_out;
        ll_cnt <= (low_light_detect_in && !srst) ? inc(ll_cnt) : 6'h00;
        do_idle <= (do_neg_in || srst) ? 6'h00 : inc(do_idle);
        rx_quiet <= (fiber_receive_in != rx_prev || srst) ? 6'h00
            : inc(rx_quiet);
        fib_run <= (fiber_led_sink_out != fib_prev || srst) ? 6'h00
            : inc(fib_run);
        jab_run <= (babble_guard_led_n || srst) ? 6'h00 : inc(jab_run);
        quiet_cnt <= (loopback_off_strap && !heartbeat_test_strap
            && babble_guard_led_n && !srst) ? inc(quiet_cnt) : 6'h00;
        tl_run <= (transmit_led_n || srst) ? 0 : tl_run + 1;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_full_duplex_quiet: assert property (
        quiet_cnt >= 6'h08 |-> !col_out)
        else $error("collision output active in full duplex");
    a_col_high_run: assert property (
        col_out [*3] |=> !col_out)
        else $error("collision high phase too long");
    a_low_light_gate: assert property (
        (ll_cnt >= 6'h08 && do_idle >= 6'h18) |-> !di_active_out)
        else $error("receive passed while light is low");
    a_rx_idle_close: assert property (
        (rx_quiet >= 6'h18 && do_idle >= 6'h18) |-> !di_active_out)
        else $error("receive stayed open after fiber idle");
    a_jabber_col: assert property (
        !babble_guard_led_n [*6] |->
            (col_out || $past(col_out) || $past(col_out, 2)))
        else $error("collision not oscillating in jabber");
    a_jabber_tone: assert property (
        jab_run >= 6'h28 |-> fib_run <= 6'h1E)
        else $error("idle tone missing during jabber");
    a_led_stretch: assert property (
        $rose(transmit_led_n) |-> tl_run >= LED_CYC)
        else $error("transmit lamp pulse too short");
    a_low_light_led: assert property (
        ll_cnt >= 6'h08 |-> low_light_led_n)
        else $error("low light lamp lit while light is low");
endmodule // fmc_monitor

bind fmc_top fmc_monitor #(.LED_CYC(LED_CYC)) u_mon (
    .mclk(mclk), .srst(srst), .do_neg_in(do_neg_in),
    .fiber_receive_in(fiber_receive_in),
    .low_light_detect_in(low_light_detect_in),
    .loopback_off_strap(loopback_off_strap),
    .heartbeat_test_strap(heartbeat_test_strap),
    .di_active_out(di_active_out), .col_out(col_out),
    .fiber_led_sink_out(fiber_led_sink_out),
    .transmit_led_n(transmit_led_n),
    .babble_guard_led_n(babble_guard_led_n),
    .low_light_led_n(low_light_led_n)
);

// ===== sim/fmc_dte_model.sv
`timescale 1ns/100ps
module fmc_dte_model (
    // clock
    input wire logic mclk,
    // bench control
    input wire logic send,
    input wire logic blip,
    // receive pair seen by the station
    input wire logic di_active_out,
    // transmit pair and carrier flag
    output logic do_neg_in = 1'b0,
    output logic carrier_seen = 1'b0
);
    logic [2:0] ph = 3'h0;

    // 10MHz tone, 3 cycles negative then 2 positive; idle is positive
    always @(posedge mclk) begin
        ph <= (send && ph != 3'h4) ? ph + 3'h1 : 3'h0;
        do_neg_in <= (send && ph < 3'h3) || blip;
        carrier_seen <= send && (carrier_seen || di_active_out);
    end
endmodule // fmc_dte_model

// ===== sim/fiber_mau_control_tb.sv
`timescale 1ns/100ps
module fiber_mau_control_tb;
    import fmc_pkg::*;
    localparam int unsigned LEDC = 300;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic fiber_receive_in = 1'b0;
    logic low_light_detect_in = 1'b0;
    logic loopback_off_strap = 1'b0;
    logic heartbeat_test_strap = 1'b1;
    logic send = 1'b0;
    logic blip = 1'b0;
    logic [1:0] rx_mode = 2'h0;
    logic [4:0] rx_ph = 5'h00;
    logic do_neg_in, di_data_out, di_active_out, col_out, fiber_led_sink_out;
    logic transmit_led_n, receive_led_n, collision_led_n, carrier_seen;
    logic babble_guard_led_n, low_light_led_n;
    int errors = 0;
    int checks_done = 0;
    int n_col, n_di, n_fib, n_dd, first_col, n;

    fmc_top #(.JAB_CYC(200), .UNJAB_CYC(300), .LED_CYC(LEDC)) dut (
        .mclk(mclk), .srst(srst), .do_neg_in(do_neg_in),
        .di_data_out(di_data_out), .di_active_out(di_active_out),
        .col_out(col_out), .fiber_led_sink_out(fiber_led_sink_out),
        .fiber_receive_in(fiber_receive_in),
        .low_light_detect_in(low_light_detect_in),
        .loopback_off_strap(loopback_off_strap),
        .heartbeat_test_strap(heartbeat_test_strap),
        .transmit_led_n(transmit_led_n), .receive_led_n(receive_led_n),
        .collision_led_n(collision_led_n),
        .babble_guard_led_n(babble_guard_led_n),
        .low_light_led_n(low_light_led_n));
    fmc_dte_model dte (.mclk(mclk), .send(send), .blip(blip),
        .di_active_out(di_active_out), .do_neg_in(do_neg_in),
        .carrier_seen(carrier_seen));

    initial begin
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------
    // fiber source: 1 = 10MHz data, 2 = 1MHz idle tone
    // ----------------------------------------
    always @(posedge mclk) begin
        rx_ph <= (rx_ph == ((rx_mode == 2'h2) ? 5'h18 : 5'h04)) ? 5'h00
            : rx_ph + 5'h01;
        if (rx_mode == 2'h1 && (rx_ph == 5'h00 || rx_ph == 5'h03))
            fiber_receive_in <= ~fiber_receive_in;
        else if (rx_mode == 2'h2 && rx_ph == 5'h00)
            fiber_receive_in <= ~fiber_receive_in;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // sample 1ns after each edge so that edge's updates have landed
    task automatic run(input int cyc);
        logic pc;
        logic pd;
        pc = fiber_led_sink_out;
        pd = di_data_out;
        n_dd = 0;
        n_col = 0;
        n_di = 0;
        n_fib = 0;
        first_col = -1;
        for (int i = 0; i < cyc; i++) begin
            @(posedge mclk);
            #1;
            if (col_out === 1'b1 && first_col < 0)
                first_col = i;
            n_col += (col_out === 1'b1);
            n_di += (di_active_out === 1'b1);
            n_fib += (fiber_led_sink_out !== pc);
            pc = fiber_led_sink_out;
            n_dd += (di_data_out !== pd);
            pd = di_data_out;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_tx;
        // a one-cycle negative blip is noise and must stay squelched
        @(posedge mclk);
        blip <= 1'b1;
        @(posedge mclk);
        blip <= 1'b0;
        run(30);
        chk(n_di, 0);
        @(posedge mclk);
        send <= 1'b1;
        run(60);
        chk(carrier_seen, 1);
        chk(n_dd > 10, 1);
        chk(n_di >= 50, 1);
        chk(n_fib > 10, 1);
        chk(transmit_led_n, 0);
        @(posedge mclk);
        send <= 1'b0;
        run(120);
        chk(n_di >= 10 && n_di <= 20, 1);
        chk(n_fib >= 4 && n_fib <= 10, 1);
        chk(first_col >= 30 && first_col <= 80, 1);
        chk(n_col >= 20 && n_col <= 40, 1);
        n = 0;
        while (transmit_led_n !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 1000) begin
                chk(transmit_led_n, 1);
                close_out();
            end
        end
        chk(n + 120 >= LEDC && n + 120 <= LEDC + 40, 1);
        $display("test transmit done");
    endtask

    task automatic t_nosqe;
        @(posedge mclk);
        heartbeat_test_strap <= 1'b0;
        send <= 1'b1;
        run(40);
        @(posedge mclk);
        send <= 1'b0;
        run(150);
        chk(n_col, 0);
        $display("test heartbeat off done");
    endtask

    task automatic t_rx;
        @(posedge mclk);
        rx_mode <= 2'h1;
        run(60);
        chk(n_di > 30, 1);
        chk(receive_led_n, 0);
        chk(low_light_led_n, 0);
        @(posedge mclk);
        rx_mode <= 2'h0;
        run(20);
        chk(di_active_out, 0);
        @(posedge mclk);
        rx_mode <= 2'h2;
        run(200);
        chk(n_di, 0);
        @(posedge mclk);
        low_light_detect_in <= 1'b1;
        rx_mode <= 2'h1;
        run(100);
        chk(n_di, 0);
        chk(low_light_led_n, 1);
        @(posedge mclk);
        low_light_detect_in <= 1'b0;
        rx_mode <= 2'h0;
        run(20);
        $display("test receive done");
    endtask

    task automatic t_col;
        @(posedge mclk);
        send <= 1'b1;
        rx_mode <= 2'h1;
        run(60);
        chk(n_col > 15, 1);
        chk(n_di > 30, 1);
        chk(collision_led_n, 0);
        @(posedge mclk);
        send <= 1'b0;
        run(30);
        run(30);
        chk(n_col, 0);
        @(posedge mclk);
        loopback_off_strap <= 1'b1;
        rx_mode <= 2'h0;
        run(40);
        @(posedge mclk);
        send <= 1'b1;
        run(60);
        chk(n_di, 0);
        chk(n_dd, 0);
        @(posedge mclk);
        rx_mode <= 2'h1;
        run(60);
        chk(n_col, 0);
        chk(n_di > 30, 1);
        @(posedge mclk);
        send <= 1'b0;
        rx_mode <= 2'h0;
        loopback_off_strap <= 1'b0;
        heartbeat_test_strap <= 1'b1;
        run(150);
        $display("test collision done");
    endtask

    task automatic t_jab;
        @(posedge mclk);
        send <= 1'b1;
        run(300);
        chk(babble_guard_led_n, 0);
        chk(n_col > 30, 1);
        run(60);
        chk(n_fib >= 2 && n_fib <= 4, 1);
        @(posedge mclk);
        send <= 1'b0;
        run(250);
        chk(babble_guard_led_n, 0);
        run(100);
        chk(babble_guard_led_n, 1);
        $display("test jabber done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (10) @(posedge mclk);
        t_tx();
        t_nosqe();
        t_rx();
        t_col();
        t_jab();
        close_out();
    end
endmodule // fiber_mau_control_tb
